// file: rc_pkg.sv
package rc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FINE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_COARSE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_MOD = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CHECK = 4'h4;
  localparam logic [DATA_W-1:0] RST_FINE = 8'hB0;
  localparam logic [DATA_W-1:0] RST_COARSE = 8'h0B;
  localparam logic [DATA_W-1:0] RST_MOD = 8'h28;
  localparam logic [DATA_W-1:0] RST_CHECK = 8'h50;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
  // fine_frequency_and_packet_mode fields
  localparam int FINE_MSB = 7;
  localparam int FINE_LSB = 1;
  localparam int PMODE_BIT = 0;
  // coarse_frequency_supply_clock_enable fields
  localparam int COARSE_MSB = 3;
  localparam int COARSE_LSB = 2;
  localparam int SUPPLY_BIT = 1;
  localparam int CLKOUT_BIT = 0;
  // modulation_sleep_config fields
  localparam int ASK_BIT = 7;
  localparam int SLEEP_MSB = 6;
  localparam int SLEEP_LSB = 2;
  localparam int SLEEP_EXTEND_BIT = 1;
  localparam int LIMIT_EXTEND_BIT = 0;
  // bitcheck_and_min_limit fields
  localparam int CHK_MSB = 7;
  localparam int CHK_LSB = 6;
  localparam int LIM_MSB = 5;
  localparam int LIM_LSB = 0;
  // trim arithmetic
  localparam int TRIM_W = 9;
  localparam logic [TRIM_W-1:0] COARSE_STEP = 9'h080;
  localparam int FRAC_DIVISOR = 16384;
  // timing
  localparam int SLEEP_UNIT = 1024;
  localparam int SLEEP_XMUL = 8;
  localparam int SLEEP_CNT_W = 18;
  localparam int LIM_XMUL = 2;
  localparam int XD_CNT_W = 5;
  localparam int LIM_W = 6;
  localparam logic [1:0] OPM_TX = 2'h1;
  localparam logic [1:0] OPM_POLL = 2'h2;
  localparam logic [1:0] OPM_RX = 2'h3;
  typedef enum logic [1:0] {
    RC_SLEEP_IDLE = 2'b01,
    RC_SLEEP_RUN = 2'b10
  } rc_sleep_e;
endpackage

// file: rc_config_regs.sv
// Operation
// - fine trim in bits 7..1 of register 1, low trim part, resets to 88
// - rf frequency steps crystal over 16384 per trim unit
// - in rx, bit-check success raises irq only when packet bit is 0
// - in tx, packet bit 0 means manchester, 1 means raw nrz
// - coarse code gives 0, 128, 256 or 384; resets to 256
// - register 2 bit 1 switches external supply, resets on
// - bit-check ok in rx or poll, key event or power-on status force supply and clock on
// - register 2 bit 0 enables clock output, resets enabled
// - register 3 bit 7 selects fsk at 0, ask at 1
// - sleep value bits 6..2, time is value x 1024 x multiplier, reset 10
// - register 3 bit 1 sets sleep multiplier 1 or 8
// - register 3 bit 0 sets edge-limit multiplier 1 or 2
// - register 4 bits 7..6 select 0, 3, 6 or 9 checked bits; reset 3
// - rx minimum edge time is limit field x extended clock period
// - tx baud is one over twice (limit plus one) extended periods
// - extended period is digital period x limit mult x 8, 4, 2 or 1
`timescale 1ns/1ps
`default_nettype none
module rc_config_regs
  import rc_pkg::*;
#(
  parameter int DCLK_DIV = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  output logic [DATA_W-1:0] rdData,
  input wire logic [1:0] opMode,
  input wire logic [1:0] rateRangeSelect,
  input wire logic bitCheckOk,
  input wire logic powerOnStatus,
  input wire logic [4:0] keyInputs,
  input wire logic sleepStart,
  input wire logic rxEdge,
  output logic [TRIM_W-1:0] rfTrim,
  output logic irqBitCheck,
  output logic manchesterEnable,
  output logic extSupplyEnable,
  output logic clockOutEnable,
  output logic amplitudeNotFrequencyKeying,
  output logic [3:0] bitCheckLength,
  output logic sleepActive,
  output logic sleepDone,
  output logic txHalfBitTick,
  output logic edgeTooShort
);

  function automatic logic [TRIM_W-1:0] coarse_freq_value(
    input logic [1:0] code
  );
    coarse_freq_value = COARSE_STEP * code;
  endfunction

  function automatic logic [3:0] check_length(input logic [1:0] code);
    check_length = 4'h3 * code;
  endfunction

  function automatic logic [XD_CNT_W-1:0] xd_mult(
    input logic [1:0] range,
    input logic limit_extend
  );
    logic [XD_CNT_W-1:0] base;
    base = 5'h08 >> range;
    xd_mult = limit_extend ? base * LIM_XMUL[XD_CNT_W-1:0] : base;
  endfunction

  function automatic logic wr_hit(
    input logic en,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    wr_hit = en && (a == target);
  endfunction

  logic [DATA_W-1:0] fineFrequencyAndPacketMode;
  logic [DATA_W-1:0] coarseFrequencySupplyClockEnable;
  logic [DATA_W-1:0] modulationSleepConfig;
  logic [DATA_W-1:0] bitcheckAndMinLimit;

  logic [4:0] keySync1;
  logic [4:0] keySync2;
  logic [4:0] keyPrev;
  logic keyEvent;
  logic rxActive;
  logic forceOn;

  logic [1:0] coarseFreqTrim;
  logic [6:0] fineFreqTrim;
  logic packetMode;
  logic [4:0] sleepValue;
  logic sleepExtend;
  logic limitExtend;
  logic [LIM_W-1:0] minLimit;

  assign fineFreqTrim = fineFrequencyAndPacketMode[FINE_MSB:FINE_LSB];
  assign packetMode = fineFrequencyAndPacketMode[PMODE_BIT];
  assign coarseFreqTrim =
    coarseFrequencySupplyClockEnable[COARSE_MSB:COARSE_LSB];
  assign sleepValue = modulationSleepConfig[SLEEP_MSB:SLEEP_LSB];
  assign sleepExtend = modulationSleepConfig[SLEEP_EXTEND_BIT];
  assign limitExtend = modulationSleepConfig[LIMIT_EXTEND_BIT];
  assign minLimit = bitcheckAndMinLimit[LIM_MSB:LIM_LSB];

  // key pins are asynchronous; only the second stage feeds logic
  // reset to the pulled-up idle level, else a false event follows reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keySync1 <= '1;
      keySync2 <= '1;
      keyPrev <= '1;
    end else begin
      keySync1 <= keyInputs;
      keySync2 <= keySync1;
      keyPrev <= keySync2;
    end
  end

  assign keyEvent = |(keySync2 ^ keyPrev);
  assign rxActive = (opMode == OPM_RX) || (opMode == OPM_POLL);
  assign forceOn = (bitCheckOk && rxActive) || keyEvent
    || powerOnStatus;

  // register writes; hardware force wins over a host clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fineFrequencyAndPacketMode <= RST_FINE;
    end else if (wr_hit(wrEn, addr, ADDR_FINE)) begin
      fineFrequencyAndPacketMode <= wrData;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coarseFrequencySupplyClockEnable <= RST_COARSE;
    end else begin
      if (wr_hit(wrEn, addr, ADDR_COARSE)) begin
        coarseFrequencySupplyClockEnable <= wrData;
      end
      if (forceOn) begin
        coarseFrequencySupplyClockEnable[SUPPLY_BIT] <= 1'b1;
        coarseFrequencySupplyClockEnable[CLKOUT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modulationSleepConfig <= RST_MOD;
    end else if (wr_hit(wrEn, addr, ADDR_MOD)) begin
      modulationSleepConfig <= wrData;
    end
  end

  // values below 10 are stored as written; host keeps them in range
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitcheckAndMinLimit <= RST_CHECK;
    end else if (wr_hit(wrEn, addr, ADDR_CHECK)) begin
      bitcheckAndMinLimit <= wrData;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData <= RD_UNMAPPED;
    end else begin
      case (addr)
        ADDR_FINE: rdData <= fineFrequencyAndPacketMode;
        ADDR_COARSE: rdData <= coarseFrequencySupplyClockEnable;
        ADDR_MOD: rdData <= modulationSleepConfig;
        ADDR_CHECK: rdData <= bitcheckAndMinLimit;
        default: rdData <= RD_UNMAPPED;
      endcase
    end
  end

  // decoded config outputs, registered to keep outputs glitch free
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rfTrim <= '0;
      manchesterEnable <= 1'b0;
      extSupplyEnable <= 1'b0;
      clockOutEnable <= 1'b0;
      amplitudeNotFrequencyKeying <= 1'b0;
      bitCheckLength <= '0;
    end else begin
      // one trim unit moves the synthesizer by f_xtal / FRAC_DIVISOR
      rfTrim <= coarse_freq_value(coarseFreqTrim)
        + {2'b00, fineFreqTrim};
      manchesterEnable <= (opMode == OPM_TX) && !packetMode;
      extSupplyEnable <= coarseFrequencySupplyClockEnable[SUPPLY_BIT];
      clockOutEnable <= coarseFrequencySupplyClockEnable[CLKOUT_BIT];
      amplitudeNotFrequencyKeying <= modulationSleepConfig[ASK_BIT];
      bitCheckLength <= check_length(
        bitcheckAndMinLimit[CHK_MSB:CHK_LSB]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqBitCheck <= 1'b0;
    end else begin
      irqBitCheck <= bitCheckOk && rxActive && !packetMode;
    end
  end

  // digital clock enable from the system clock
  logic [15:0] dclkCnt;
  logic dclkTick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dclkCnt <= '0;
      dclkTick <= 1'b0;
    end else if (dclkCnt == 16'(DCLK_DIV - 1)) begin
      dclkCnt <= '0;
      dclkTick <= 1'b1;
    end else begin
      dclkCnt <= dclkCnt + 16'h0001;
      dclkTick <= 1'b0;
    end
  end

  // extended data clock: range divider times limit multiplier
  logic [XD_CNT_W-1:0] xdCnt;
  logic [XD_CNT_W-1:0] xdMult;
  logic xdTick;

  assign xdMult = xd_mult(rateRangeSelect, limitExtend);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xdCnt <= '0;
      xdTick <= 1'b0;
    end else begin
      xdTick <= 1'b0;
      if (dclkTick) begin
        if (xdCnt >= xdMult - 5'h01) begin
          xdCnt <= '0;
          xdTick <= 1'b1;
        end else begin
          xdCnt <= xdCnt + 5'h01;
        end
      end
    end
  end

  // tx half bit every limit+1 extended periods: bit is twice that
  logic [LIM_W-1:0] txCnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txCnt <= '0;
      txHalfBitTick <= 1'b0;
    end else begin
      txHalfBitTick <= 1'b0;
      if (opMode != OPM_TX) begin
        txCnt <= '0;
      end else if (xdTick) begin
        if (txCnt >= minLimit) begin
          txCnt <= '0;
          txHalfBitTick <= 1'b1;
        end else begin
          txCnt <= txCnt + 6'h01;
        end
      end
    end
  end

  // rx edge spacing in extended periods, saturating at field maximum
  logic [LIM_W-1:0] edgeCnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      edgeCnt <= '1;
      edgeTooShort <= 1'b0;
    end else begin
      edgeTooShort <= 1'b0;
      if (!rxActive) begin
        edgeCnt <= '1;
      end else if (rxEdge) begin
        edgeTooShort <= (edgeCnt < minLimit);
        edgeCnt <= '0;
      end else if (xdTick && edgeCnt != '1) begin
        edgeCnt <= edgeCnt + 6'h01;
      end
    end
  end

  // polling sleep timer counted in digital clock periods
  rc_sleep_e sleepState;
  logic [SLEEP_CNT_W-1:0] sleepCnt;
  logic [SLEEP_CNT_W-1:0] sleepTarget;

  always_comb begin
    sleepTarget = SLEEP_CNT_W'(sleepValue) * SLEEP_CNT_W'(SLEEP_UNIT);
    if (sleepExtend) begin
      sleepTarget = sleepTarget * SLEEP_CNT_W'(SLEEP_XMUL);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepState <= RC_SLEEP_IDLE;
      sleepCnt <= '0;
      sleepActive <= 1'b0;
      sleepDone <= 1'b0;
    end else begin
      sleepDone <= 1'b0;
      case (sleepState)
        RC_SLEEP_IDLE: begin
          sleepCnt <= '0;
          if (sleepStart) begin
            // zero sleep value ends on the next cycle
            if (sleepTarget == '0) begin
              sleepDone <= 1'b1;
            end else begin
              sleepState <= RC_SLEEP_RUN;
              sleepActive <= 1'b1;
            end
          end
        end
        RC_SLEEP_RUN: begin
          if (dclkTick) begin
            if (sleepCnt == sleepTarget - 1'b1) begin
              sleepState <= RC_SLEEP_IDLE;
              sleepActive <= 1'b0;
              sleepDone <= 1'b1;
            end else begin
              sleepCnt <= sleepCnt + 1'b1;
            end
          end
        end
        default: begin
          sleepState <= RC_SLEEP_IDLE;
          sleepActive <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: rc_config_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rc_config_regs_checker
  import rc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic [1:0] opMode,
  input wire logic bitCheckOk,
  input wire logic powerOnStatus,
  input wire logic sleepStart,
  input wire logic irqBitCheck,
  input wire logic manchesterEnable,
  input wire logic extSupplyEnable,
  input wire logic clockOutEnable,
  input wire logic amplitudeNotFrequencyKeying,
  input wire logic [3:0] bitCheckLength,
  input wire logic sleepActive,
  input wire logic sleepDone
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_force;
    (bitCheckOk && opMode[1]) || powerOnStatus;
  endsequence
  sequence s_on;
    extSupplyEnable && clockOutEnable;
  endsequence
  // register is set on the next edge, its decoded copy one edge later
  property p_force;
    s_force |-> ##2 s_on;
  endproperty
  a_force: assert property (p_force) else $error("not forced on");
  property p_irq;
    irqBitCheck |-> $past(bitCheckOk) && $past(opMode[1]);
  endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_manch;
    manchesterEnable |-> $past(opMode) == OPM_TX;
  endproperty
  a_manch: assert property (p_manch) else $error("encoder on");
  // read data and decoded copies sample the register on the same edge
  property p_en;
    addr == ADDR_COARSE |=>
      {extSupplyEnable, clockOutEnable} == rdData[1:0];
  endproperty
  a_en: assert property (p_en) else $error("enable copy");
  property p_ask;
    addr == ADDR_MOD |=>
      amplitudeNotFrequencyKeying == rdData[ASK_BIT];
  endproperty
  a_ask: assert property (p_ask) else $error("keying copy");
  property p_len;
    addr == ADDR_CHECK |=>
      bitCheckLength == 4'(3 * rdData[CHK_MSB:CHK_LSB]);
  endproperty
  a_len: assert property (p_len) else $error("check length");
  property p_unmap;
    addr == 4'h0 || addr > ADDR_CHECK |=> rdData == RD_UNMAPPED;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_sleep;
    $rose(sleepActive) |-> $past(sleepStart);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep start");
  property p_done;
    sleepDone |=> !sleepDone;
  endproperty
  a_done: assert property (p_done) else $error("done width");
endmodule
bind rc_config_regs rc_config_regs_checker rc_config_regs_checker_inst (
  .clk_sys, .rst, .addr, .rdData, .opMode, .bitCheckOk, .powerOnStatus,
  .sleepStart, .irqBitCheck, .manchesterEnable, .extSupplyEnable,
  .clockOutEnable, .amplitudeNotFrequencyKeying, .bitCheckLength,
  .sleepActive, .sleepDone);
`default_nettype wire

// file: rc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rc_host
  import rc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [DATA_W-1:0] rdData,
  output logic wrEn,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wrData
);
  initial begin
    wrEn = 1'b0;
    addr = 4'h0;
    wrData = 8'h00;
  end
  // limit only 10..63; supply cleared only by the force test, no aux mode here
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(negedge clk_sys);
    wrEn = 1'b0;
    wrData = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    @(negedge clk_sys);
    d = rdData;
  endtask
endmodule
`default_nettype wire

// file: rc_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rc_config_regs_tb
  import rc_pkg::*;
;
  localparam int DIV = 2;
  logic clk_sys, rst, wrEn, bitCheckOk, powerOnStatus, sleepStart, rxEdge;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData, rdData, rv;
  logic [1:0] opMode, rateRangeSelect;
  logic [4:0] keyInputs;
  logic [TRIM_W-1:0] rfTrim;
  logic [3:0] bitCheckLength;
  logic irqBitCheck, manchesterEnable, extSupplyEnable, clockOutEnable;
  logic amplitudeNotFrequencyKeying, sleepActive, sleepDone;
  logic txHalfBitTick, edgeTooShort;
  int n_errors, checked, cycles;
  rc_config_regs #(.DCLK_DIV(DIV)) rc_config_regs_inst (.*);
  rc_host rc_host_inst (.clk_sys(clk_sys), .rdData(rdData), .wrEn(wrEn),
    .addr(addr), .wrData(wrData));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] rstVal [4];
    rstVal = '{{7'h58, 1'b0}, 8'h0B, {1'b0, 5'h0A, 2'h0}, {2'h1, 6'h10}};
    for (int a = 0; a < 6; a++) begin
      rc_host_inst.rd(4'(a), rv);
      check("reg", rv, (a inside {[1:4]}) ? rstVal[(a+3)%4] : 8'h00);
    end
    check("trim", rfTrim, 9'h158);
    check("len", bitCheckLength, 4'h3);
    check("en", {extSupplyEnable, clockOutEnable}, 2'h3);
  endtask
  task automatic t_decode;
    for (int c = 0; c < 4; c++) begin
      rc_host_inst.wr(ADDR_COARSE, {4'h0, 2'(c), 2'h3});
      rc_host_inst.wr(ADDR_CHECK, {2'(c), 6'h0A});
      repeat (2) @(negedge clk_sys);
      check("coarse", rfTrim, 16'(c * 128 + 88));
      check("chkLen", bitCheckLength, 16'(c * 3));
    end
    rc_host_inst.wr(ADDR_FINE, 8'hFF);
    opMode = OPM_TX;
    repeat (2) @(negedge clk_sys);
    check("trimMax", rfTrim, 9'h1FF);
    check("nrz", manchesterEnable, 1'h0);
    rc_host_inst.wr(ADDR_FINE, 8'hB0);
    repeat (2) @(negedge clk_sys);
    check("manch", manchesterEnable, 1'h1);
    rc_host_inst.rd(ADDR_FINE, rv);
    check("hold", rv, 8'hB0);
  endtask
  task automatic t_force;
    logic irq;
    for (int k = 0; k < 4; k++) begin
      rc_host_inst.wr(ADDR_COARSE, 8'h08);
      repeat (2) @(negedge clk_sys);
      check("off", {extSupplyEnable, clockOutEnable}, 2'h0);
      opMode = (k == 1) ? OPM_RX : 2'h0;
      powerOnStatus = (k == 0);
      bitCheckOk = (k == 1 || k == 2);
      keyInputs = (k == 3) ? 5'h1E : 5'h1F;
      @(negedge clk_sys);
      irq = irqBitCheck;
      powerOnStatus = 1'b0;
      bitCheckOk = 1'b0;
      repeat (6) @(negedge clk_sys);
      check("forced", {extSupplyEnable, clockOutEnable}, (k == 2) ? 0 : 3);
      check("irq", irq, k == 1);
    end
  endtask
  task automatic t_tick(input logic [1:0] r, input logic x, input int exp);
    int n;
    rc_host_inst.wr(ADDR_CHECK, 8'h4A);
    rc_host_inst.wr(ADDR_MOD, {7'h00, x});
    rateRangeSelect = r;
    opMode = OPM_TX;
    // first gap may straddle the settings change
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (txHalfBitTick !== 1'b1 && n < 400);
    end
    check("tickGap", 16'(n), 16'(exp));
  endtask
  task automatic t_sleep(input logic [7:0] d, input int exp);
    int n;
    logic inWin;
    rc_host_inst.wr(ADDR_MOD, d);
    repeat (2) @(negedge clk_sys);
    sleepStart = 1'b1;
    @(negedge clk_sys);
    sleepStart = 1'b0;
    check("active", sleepActive, 1'h1);
    n = 1;
    while (sleepDone !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    // digital tick phase adds up to one tick of slack
    inWin = n >= exp + 2 - DIV && n <= exp + 1;
    check("sleep", inWin, 1'h1);
    check("idle", sleepActive, 1'h0);
    check("ask", amplitudeNotFrequencyKeying, d[7]);
  endtask
  task automatic t_edge;
    logic [2:0] seen;
    rc_host_inst.wr(ADDR_CHECK, 8'h50);
    rateRangeSelect = 2'h3;
    opMode = OPM_RX;
    // first edge after a long idle, then a close one, then a wide one
    for (int k = 0; k < 3; k++) begin
      repeat ((k == 2) ? 80 : 10) @(negedge clk_sys);
      rxEdge = 1'b1;
      @(negedge clk_sys);
      rxEdge = 1'b0;
      seen[k] = edgeTooShort;
    end
    check("short", seen, 3'b010);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    {bitCheckOk, powerOnStatus, sleepStart, rxEdge} = 4'h0;
    opMode = 2'h0;
    rateRangeSelect = 2'h2;
    keyInputs = 5'h1F;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_decode();
    t_force();
    t_tick(2'h3, 1'b0, 11 * DIV);
    t_tick(2'h1, 1'b1, 11 * 4 * 2 * DIV);
    t_sleep(8'h84, 1024 * DIV);
    t_sleep(8'h86, 8 * 1024 * DIV);
    t_edge();
    close_out();
  end
endmodule
`default_nettype wire
